// file: common/wwdt_pkg.sv
package wwdt_pkg;

  // ----------------------------------------------------------------
  // register map (byte-wide registers on a plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h1;
  localparam logic [3:0] ADDR_PS_LOW = 4'h2;
  localparam logic [3:0] ADDR_PS_HIGH = 4'h3;
  localparam logic [3:0] ADDR_COUNT_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int CS_LSB = 4;
  localparam int WIN_LSB = 0;
  localparam int PERIOD_LSB = 1;
  localparam int SWEN_BIT = 0;
  localparam int COUNT_LSB = 3;
  localparam int ARMED_BIT = 2;
  localparam int PSTOP_LSB = 0;
  localparam logic [2:0] CODE_ALL_ONES = 3'h7;
  localparam logic [2:0] CS_LOW_OSC = 3'h0;
  localparam logic [2:0] CS_MID_OSC = 3'h1;
  localparam logic [4:0] PERIOD_RESET = 5'h0B;
  localparam logic [4:0] PERIOD_MAX = 5'h12;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_VIOL = 1;
  localparam int IRQ_BITS = 2;

  // ----------------------------------------------------------------
  // timing: tick rates derived from the 50 MHz system clock
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 50000000;
  localparam int LOW_OSC_HZ = 31000;
  localparam int MID_OSC_HZ = 31250;
  localparam int LOW_DIV = SYS_CLK_HZ / LOW_OSC_HZ;
  localparam int MID_DIV = SYS_CLK_HZ / MID_OSC_HZ;
  localparam int PS_WIDTH = 18;
  localparam int CNT_WIDTH = 5;
  localparam int PS_BASE_LOG = 5;
  localparam int DIV_WIDTH = 11;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wwdt_bus_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] clk_default;
    logic [2:0] win_default;
    logic [4:0] period_default;
  } wwdt_cfg_type;

endpackage

// file: verilog/wwdt_tick_div.sv
`timescale 1ns/100ps
// one-cycle tick at the selected oscillator rate
module wwdt_tick_div (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic [2:0] i_sel,
  output logic o_tick
);

  typedef struct packed {
    logic [wwdt_pkg::DIV_WIDTH-1:0] cnt;
    logic tick;
  } wwdt_div_state_type;

  wwdt_div_state_type st_r;
  wwdt_div_state_type st_nxt;
  logic [wwdt_pkg::DIV_WIDTH-1:0] limit;

  // --------------------------------------------------------------
  // divider
  // --------------------------------------------------------------
  // reserved codes fall back to the low oscillator rate
  always_comb begin
    limit = (i_sel == wwdt_pkg::CS_MID_OSC) ? wwdt_pkg::DIV_WIDTH'(wwdt_pkg::MID_DIV - 1)
                                             : wwdt_pkg::DIV_WIDTH'(wwdt_pkg::LOW_DIV - 1);
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (i_clear) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= limit) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;

endmodule // wwdt_tick_div

// file: verilog/wwdt_window_cmp.sv
`timescale 1ns/100ps
// window comparator: open once count eighths passed the closed delay
module wwdt_window_cmp (
  input wire logic [wwdt_pkg::CNT_WIDTH-1:0] i_count,
  input wire logic [2:0] i_win,
  output logic o_open
);

  logic [3:0] closed_eighths;

  // code 111 has no closed part; each lower code closes one more eighth
  always_comb begin
    closed_eighths = 4'(wwdt_pkg::CODE_ALL_ONES - i_win);
    o_open = ({1'b0, i_count[wwdt_pkg::CNT_WIDTH-1:2]} >= closed_eighths);
  end

endmodule // wwdt_window_cmp

// file: verilog/wwdt_ctrl.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
//
// Behaviour
// - select low or mid oscillator time base
// - window code sets closed eighths of period
// - clock select bits 6-4, window 2-0
// - bits 7 and 3 read zero
// - clock select resets to its default, or to low oscillator when default 111
// - window field resets from configuration default
// - clock select writable only when default 111
// - window writable only when default 111
// - prescale count split over three registers
// - count registers read-only, reset zero
// - watchdog count bits 6-3, bit7 zero
// - armed status in bit 2
// - clear outside window causes reset
// - clear while unarmed causes reset
// - control writes clear both counters
module wwdt_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_clear_instr,
  input wire logic i_sleep,
  input wire logic [1:0] i_cfg_mode,
  input wire logic [2:0] i_cfg_tick_clock_default,
  input wire logic [2:0] i_cfg_window_size_default,
  input wire logic [4:0] i_cfg_period_default,
  output logic o_guard_reset,
  output logic o_wake,
  output logic o_irq
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clk_sel;
    logic [2:0] win;
    logic [4:0] period;
    logic sw_en;
    logic [wwdt_pkg::PS_WIDTH-1:0] ps;
    logic [wwdt_pkg::CNT_WIDTH-1:0] cnt;
    logic armed;
    logic [wwdt_pkg::IRQ_BITS-1:0] irq_stat;
    logic [wwdt_pkg::IRQ_BITS-1:0] irq_mask;
    logic [7:0] rdata;
    logic rst_pulse;
    logic wake;
    logic sleep_d;
  } wwdt_state_type;

  wwdt_state_type st_r;
  wwdt_state_type st_nxt;
  wwdt_pkg::wwdt_bus_type bus;
  wwdt_pkg::wwdt_cfg_type cfg;
  logic tick;
  logic win_open;
  logic active;
  logic ctrl_wr;
  logic ps_done;
  logic timeout;
  logic violation;
  logic clr_ok;
  logic cnt_clear;
  logic [wwdt_pkg::PS_WIDTH-1:0] ps_limit;
  logic [wwdt_pkg::IRQ_BITS-1:0] irq_ev;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign cfg = '{mode: i_cfg_mode, clk_default: i_cfg_tick_clock_default,
                 win_default: i_cfg_window_size_default,
                 period_default: i_cfg_period_default};

  // --------------------------------------------------------------
  // time base and window
  // --------------------------------------------------------------
  // time base select
  wwdt_tick_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_clear(cnt_clear),
    .i_sel(st_r.clk_sel),
    .o_tick(tick)
  );

  wwdt_window_cmp u_win (
    .i_count(st_r.cnt),
    .i_win(st_r.win),
    .o_open(win_open)
  );

  // --------------------------------------------------------------
  // control decode
  // --------------------------------------------------------------
  // enable mode, write decode, period limit and clear conditions
  always_comb begin
    case (cfg.mode)
      wwdt_pkg::MODE_OFF: active = 1'b0;
      wwdt_pkg::MODE_SW: active = st_r.sw_en;
      2'h2: active = !i_sleep;
      default: active = 1'b1;
    endcase
    ctrl_wr = bus.wr && (bus.addr == wwdt_pkg::ADDR_CTRL_ZERO ||
                         bus.addr == wwdt_pkg::ADDR_CTRL_ONE);
    // prescale of 2^code ticks per count (2^(5+code) per period); reserved codes give the minimum
    if (st_r.period > wwdt_pkg::PERIOD_MAX) begin
      ps_limit = wwdt_pkg::PS_WIDTH'(0);
    end else if (st_r.period == wwdt_pkg::PERIOD_MAX) begin
      // top code fills all 18 bits, where the shift below would wrap
      ps_limit = {wwdt_pkg::PS_WIDTH{1'b1}};
    end else begin
      ps_limit = wwdt_pkg::PS_WIDTH'((18'h00001 << st_r.period) - 1'b1);
    end
    ps_done = tick && (st_r.ps >= ps_limit);
    timeout = active && ps_done && (st_r.cnt == {wwdt_pkg::CNT_WIDTH{1'b1}});
    violation = active && i_clear_instr && (!win_open || !st_r.armed);
    clr_ok = i_clear_instr && !violation;
    cnt_clear = ctrl_wr || clr_ok || !active || (i_sleep != st_r.sleep_d);
    irq_ev = '0;
    irq_ev[wwdt_pkg::IRQ_TIMEOUT] = timeout;
    irq_ev[wwdt_pkg::IRQ_VIOL] = violation;
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_pulse = (timeout && !i_sleep) || violation;
    st_nxt.wake = timeout && i_sleep;
    // sleep level kept so entry and exit both clear the counters
    st_nxt.sleep_d = i_sleep;
    st_nxt.rdata = '0;
    // counters
    if (cnt_clear) begin
      st_nxt.ps = '0;
      st_nxt.cnt = '0;
    end else if (tick) begin
      if (ps_done) begin
        st_nxt.ps = '0;
        st_nxt.cnt = st_r.cnt + 1'b1;
      end else begin
        st_nxt.ps = st_r.ps + 1'b1;
      end
    end
    // arm after read, consumed by clear
    if (clr_ok || violation || ctrl_wr) begin
      st_nxt.armed = 1'b0;
    end else if (bus.rd && bus.addr == wwdt_pkg::ADDR_CTRL_ZERO) begin
      st_nxt.armed = 1'b1;
    end
    // register writes
    if (bus.wr) begin
      case (bus.addr)
        wwdt_pkg::ADDR_CTRL_ZERO: begin
          if (cfg.period_default == '1) begin
            st_nxt.period = bus.wdata[wwdt_pkg::PERIOD_LSB +: 5];
          end
          st_nxt.sw_en = bus.wdata[wwdt_pkg::SWEN_BIT];
        end
        wwdt_pkg::ADDR_CTRL_ONE: begin
          if (cfg.clk_default == wwdt_pkg::CODE_ALL_ONES) begin
            st_nxt.clk_sel = bus.wdata[wwdt_pkg::CS_LSB +: 3];
          end
          if (cfg.win_default == wwdt_pkg::CODE_ALL_ONES) begin
            st_nxt.win = bus.wdata[wwdt_pkg::WIN_LSB +: 3];
          end
        end
        wwdt_pkg::ADDR_IRQ_MASK: begin
          st_nxt.irq_mask = bus.wdata[wwdt_pkg::IRQ_BITS-1:0];
        end
        default: begin
        end
      endcase
    end
    // register reads; read of status clears, new events win
    if (bus.rd) begin
      case (bus.addr)
        wwdt_pkg::ADDR_CTRL_ZERO: begin
          st_nxt.rdata[wwdt_pkg::PERIOD_LSB +: 5] = st_r.period;
          st_nxt.rdata[wwdt_pkg::SWEN_BIT] = st_r.sw_en;
        end
        wwdt_pkg::ADDR_CTRL_ONE: begin
          st_nxt.rdata[wwdt_pkg::CS_LSB +: 3] = st_r.clk_sel;
          st_nxt.rdata[wwdt_pkg::WIN_LSB +: 3] = st_r.win;
        end
        wwdt_pkg::ADDR_PS_LOW: st_nxt.rdata = st_r.ps[7:0];
        wwdt_pkg::ADDR_PS_HIGH: st_nxt.rdata = st_r.ps[15:8];
        wwdt_pkg::ADDR_COUNT_STAT: begin
          st_nxt.rdata[wwdt_pkg::COUNT_LSB +: 4] = st_r.cnt[3:0];
          st_nxt.rdata[wwdt_pkg::ARMED_BIT] = st_r.armed;
          st_nxt.rdata[wwdt_pkg::PSTOP_LSB +: 2] = st_r.ps[17:16];
        end
        wwdt_pkg::ADDR_IRQ_STAT: begin
          st_nxt.rdata[wwdt_pkg::IRQ_BITS-1:0] = st_r.irq_stat;
          st_nxt.irq_stat = '0;
        end
        wwdt_pkg::ADDR_IRQ_MASK: begin
          st_nxt.rdata[wwdt_pkg::IRQ_BITS-1:0] = st_r.irq_mask;
        end
        default: begin
        end
      endcase
    end
    st_nxt.irq_stat = st_nxt.irq_stat | irq_ev;
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_r <= '0;
      st_r.clk_sel <= (cfg.clk_default == wwdt_pkg::CODE_ALL_ONES) ?
                      wwdt_pkg::CS_LOW_OSC : cfg.clk_default;
      st_r.win <= cfg.win_default;
      st_r.period <= (cfg.period_default == '1) ?
                     wwdt_pkg::PERIOD_RESET : cfg.period_default;
    end else begin
      st_r <= st_nxt;
    end
  end

  // count registers reset to zero and ignore writes
  assign o_rdata = st_r.rdata;
  assign o_guard_reset = st_r.rst_pulse;
  assign o_wake = st_r.wake;
  assign o_irq = |(st_r.irq_stat & st_r.irq_mask);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_unarmed_clear_rst: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    active && i_clear_instr && !st_r.armed |=> o_guard_reset)
    else $error("unarmed clear gave no reset");
  a_closed_clear_rst: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    active && i_clear_instr && !win_open |=> o_guard_reset)
    else $error("closed window clear gave no reset");
  a_ctrl_wr_clears: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ctrl_wr |=> st_r.cnt == '0 && st_r.ps == '0)
    else $error("control write did not clear counters");
  a_cs_locked: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cfg.clk_default != wwdt_pkg::CODE_ALL_ONES |=> $stable(st_r.clk_sel))
    else $error("locked clock select changed");
  a_win_locked: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cfg.win_default != wwdt_pkg::CODE_ALL_ONES |=> $stable(st_r.win))
    else $error("locked window changed");
  a_armed_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_COUNT_STAT ##1 1'b1
    |-> o_rdata[wwdt_pkg::ARMED_BIT] == $past(st_r.armed))
    else $error("armed bit readback wrong");
  a_ctrl_one_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_CTRL_ONE |=> !o_rdata[7] && !o_rdata[3])
    else $error("unimplemented bits read nonzero");
  a_arm_needs_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(st_r.armed) |-> $past(bus.rd && bus.addr == wwdt_pkg::ADDR_CTRL_ZERO))
    else $error("armed without arming read");

  // --------------------------------------------------------------
  // readback, reset and sequencing checks
  // --------------------------------------------------------------
  // readback fields follow the state one cycle after the read strobe
  a_cs_readback: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_CTRL_ONE
    |=> o_rdata[wwdt_pkg::CS_LSB +: 3] == $past(st_r.clk_sel))
    else $error("clock select readback wrong");
  a_win_readback: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_CTRL_ONE
    |=> o_rdata[wwdt_pkg::WIN_LSB +: 3] == $past(st_r.win))
    else $error("window readback wrong");
  a_ps_low_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_PS_LOW |=> o_rdata == $past(st_r.ps[7:0]))
    else $error("prescale low readback wrong");
  a_ps_high_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_PS_HIGH |=> o_rdata == $past(st_r.ps[15:8]))
    else $error("prescale high readback wrong");
  a_ps_top_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_COUNT_STAT
    |=> o_rdata[wwdt_pkg::PSTOP_LSB +: 2] == $past(st_r.ps[17:16]))
    else $error("prescale top readback wrong");
  a_count_readback: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_COUNT_STAT
    |=> o_rdata[wwdt_pkg::COUNT_LSB +: 4] == $past(st_r.cnt[3:0]))
    else $error("count readback wrong");
  a_count_top_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_COUNT_STAT |=> !o_rdata[7])
    else $error("count register top bit nonzero");
  a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !bus.rd |=> o_rdata == '0)
    else $error("read data stood without a read");
  // reset values load from the configuration levels, so no disable here
  a_cs_reset_default: assert property (@(posedge i_clk_sys)
    !i_nrst && cfg.clk_default == wwdt_pkg::CODE_ALL_ONES |=> st_r.clk_sel == wwdt_pkg::CS_LOW_OSC)
    else $error("clock select reset value wrong");
  a_win_reset: assert property (@(posedge i_clk_sys)
    !i_nrst |=> st_r.win == $past(cfg.win_default))
    else $error("window reset value wrong");
  a_count_reset: assert property (@(posedge i_clk_sys)
    !i_nrst |=> st_r.ps == '0 && st_r.cnt == '0 && !st_r.armed)
    else $error("counters not zero after reset");
  a_count_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.wr && bus.addr == wwdt_pkg::ADDR_PS_HIGH && !tick && !cnt_clear
    |=> $stable(st_r.ps))
    else $error("write changed the prescale count");
  // window decode and clear handling
  a_win_full_open: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    st_r.win == wwdt_pkg::CODE_ALL_ONES |-> win_open)
    else $error("widest window not open");
  a_win_last_eighth: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    st_r.win == '0
    |-> win_open == (st_r.cnt[4:2] == wwdt_pkg::CODE_ALL_ONES))
    else $error("narrowest window wrong");
  a_clear_ok_resets: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    active && clr_ok
    |=> st_r.cnt == '0 && st_r.ps == '0 && !st_r.armed)
    else $error("valid clear did not restart the count");
  a_arm_on_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    bus.rd && bus.addr == wwdt_pkg::ADDR_CTRL_ZERO && !bus.wr && !i_clear_instr
    |=> st_r.armed)
    else $error("arming read did not arm");
  a_armed_clear_ok: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    active && i_clear_instr && st_r.armed && win_open && !timeout
    |=> !o_guard_reset)
    else $error("valid clear gave a reset");
  a_wr_disarms: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ctrl_wr |=> !st_r.armed)
    else $error("control write left the guard armed");
  a_sleep_wake: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    timeout && i_sleep |=> o_wake && !o_guard_reset)
    else $error("sleep time-out did not wake");
  // set wins over the read that clears the status
  a_viol_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    violation |=> st_r.irq_stat[wwdt_pkg::IRQ_VIOL])
    else $error("violation status not set");
  a_inactive_idle: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !active |=> st_r.cnt == '0 && st_r.ps == '0)
    else $error("disabled guard kept counting");

endmodule // wwdt_ctrl

// file: sim/wwdt_ctrl_test.sv
`timescale 1ns/100ps
module wwdt_ctrl_test;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  // span just past five mid-rate ticks but short of five low-rate ticks
  localparam int SPAN = 8030;
  logic i_clk_sys;
  logic i_nrst;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic i_clear_instr;
  logic i_sleep;
  logic [1:0] i_cfg_mode;
  logic [2:0] i_cfg_tick_clock_default;
  logic [2:0] i_cfg_window_size_default;
  logic [4:0] i_cfg_period_default;
  logic o_guard_reset;
  logic o_wake;
  logic o_irq;
  int mismatches;
  int samples_checked;
  int n_wake;
  int n_rst;
  integer seed;
  logic [7:0] rd_val;
  logic [7:0] v;

  wwdt_ctrl wwdt_ctrl_i (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_clear_instr(i_clear_instr),
    .i_sleep(i_sleep),
    .i_cfg_mode(i_cfg_mode),
    .i_cfg_tick_clock_default(i_cfg_tick_clock_default),
    .i_cfg_window_size_default(i_cfg_window_size_default),
    .i_cfg_period_default(i_cfg_period_default),
    .o_guard_reset(o_guard_reset),
    .o_wake(o_wake),
    .o_irq(o_irq)
  );

  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  // control one layout, unimplemented bits forced low
  function automatic logic [7:0] ctl_exp(input logic [2:0] cs, input logic [2:0] win);
    return {1'b0, cs, 1'b0, win};
  endfunction

  // whole ticks seen over a span at a given divider
  function automatic logic [7:0] ticks_exp(input int span, input int div);
    return 8'(span / div);
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    bus_rd(a, rd_val);
    chk(what, exp, rd_val);
  endtask

  // counts reset pulses over four cycles, so a stuck pulse shows too
  task automatic clr_chk(input string what, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    @(posedge i_clk_sys);
    i_clear_instr <= 1'b1;
    @(posedge i_clk_sys);
    i_clear_instr <= 1'b0;
    repeat (4) begin
      #1;
      if (o_guard_reset === 1'b1) n++;
      @(posedge i_clk_sys);
    end
    chk(what, exp, n);
  endtask

  // config words only change while reset is held
  task automatic do_reset(input logic [2:0] tck, input logic [2:0] win, input logic [1:0] md);
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    i_cfg_tick_clock_default <= tck;
    i_cfg_window_size_default <= win;
    i_cfg_mode <= md;
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // tests take about 70000 cycles
  initial begin
    #1700000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    i_nrst = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_clear_instr = 1'b0;
    i_sleep = 1'b0;
    i_cfg_mode = 2'h0;
    i_cfg_tick_clock_default = 3'h7;
    i_cfg_window_size_default = 3'h7;
    i_cfg_period_default = 5'h1F; // period field writable, long reset period
    mismatches = 0;
    samples_checked = 0;
    seed = 32'hEA16A37A;
    // unlocked fields: reset values and random read-back
    do_reset(3'h7, 3'h7, 2'h3);
    rd_chk("ctrl one reset", wwdt_pkg::ADDR_CTRL_ONE, ctl_exp(3'h0, 3'h7));
    for (int k = 0; k < 6; k++) begin
      v = $random(seed);
      bus_wr(wwdt_pkg::ADDR_CTRL_ONE, v);
      rd_chk("ctrl one rw", wwdt_pkg::ADDR_CTRL_ONE, ctl_exp(v[6:4], v[2:0]));
    end
    rd_chk("unmapped", 4'hF, 8'h00);
    $display("test registers done");
    // arming, closed window, open window, unarmed clear
    bus_wr(wwdt_pkg::ADDR_CTRL_ONE, 8'h00);
    bus_rd(wwdt_pkg::ADDR_CTRL_ZERO, rd_val);
    rd_chk("armed status", wwdt_pkg::ADDR_COUNT_STAT, 8'h04);
    clr_chk("closed window clear", 8'h01);
    bus_wr(wwdt_pkg::ADDR_CTRL_ONE, 8'h07);
    bus_rd(wwdt_pkg::ADDR_CTRL_ZERO, rd_val);
    clr_chk("open window clear", 8'h00);
    rd_chk("disarmed", wwdt_pkg::ADDR_COUNT_STAT, 8'h00);
    clr_chk("unarmed clear", 8'h01);
    $display("test window done");
    // violation interrupt: masked, unmasked, cleared by read
    chk("irq masked", 8'h00, {7'h00, o_irq});
    bus_wr(wwdt_pkg::ADDR_IRQ_MASK, 8'h02);
    @(posedge i_clk_sys);
    #1;
    chk("irq unmasked", 8'h01, {7'h00, o_irq});
    rd_chk("irq status", wwdt_pkg::ADDR_IRQ_STAT, 8'h02);
    @(posedge i_clk_sys);
    #1;
    chk("irq cleared", 8'h00, {7'h00, o_irq});
    $display("test interrupt done");
    // time base: mid rate first, then low rate
    for (int k = 0; k < 2; k++) begin
      bus_wr(wwdt_pkg::ADDR_CTRL_ONE, {1'b0, 3'(1 - k), 4'h7});
      repeat (SPAN) @(posedge i_clk_sys);
      v = ticks_exp(SPAN, (k == 0) ? wwdt_pkg::MID_DIV : wwdt_pkg::LOW_DIV);
      rd_chk("prescale low", wwdt_pkg::ADDR_PS_LOW, v);
    end
    rd_chk("prescale high", wwdt_pkg::ADDR_PS_HIGH, 8'h00);
    bus_wr(wwdt_pkg::ADDR_PS_HIGH, 8'hFF);
    rd_chk("prescale high write", wwdt_pkg::ADDR_PS_HIGH, 8'h00);
    bus_wr(wwdt_pkg::ADDR_CTRL_ZERO, 8'h00);
    rd_chk("prescale after write", wwdt_pkg::ADDR_PS_LOW, 8'h00);
    $display("test time base done");
    // sleep time-out at the shortest period wakes instead of resetting
    @(posedge i_clk_sys);
    i_sleep <= 1'b1;
    n_wake = 0;
    n_rst = 0;
    repeat (33 * wwdt_pkg::LOW_DIV) begin
      @(posedge i_clk_sys);
      #1;
      if (o_wake === 1'b1) n_wake++;
      if (o_guard_reset === 1'b1) n_rst++;
    end
    chk("sleep wake", 8'h01, 8'(n_wake));
    chk("sleep no reset", 8'h00, 8'(n_rst));
    @(posedge i_clk_sys);
    i_sleep <= 1'b0;
    $display("test sleep done");
    // locked fields after a second reset
    do_reset(3'h1, 3'h2, 2'h0);
    rd_chk("ctrl one locked reset", wwdt_pkg::ADDR_CTRL_ONE, ctl_exp(3'h1, 3'h2));
    v = $random(seed);
    bus_wr(wwdt_pkg::ADDR_CTRL_ONE, v);
    rd_chk("ctrl one locked", wwdt_pkg::ADDR_CTRL_ONE, ctl_exp(3'h1, 3'h2));
    for (int k = 2; k < 5; k++) begin
      rd_chk("count regs reset", 4'(k), 8'h00);
    end
    $display("test locked done");
    report_and_stop();
  end

endmodule // wwdt_ctrl_test
